// >>> verilog/relay_card_pkg.sv
// constants shared by the relay output card files
package relay_card_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_OUTPUT_WORD = 5'h00;
  localparam logic [4:0] OFF_CONTROL = 5'h04;
  localparam logic [4:0] OFF_FLAG_TEST = 5'h08;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
  localparam int MAP_ADDR_W = 5;

  // relay word layout
  localparam int RELAY_W = 16;
  localparam int GROUP_W = 8;

  // control register, write side
  localparam int CTL_SET_CONTROL_BIT = 0;
  localparam int CTL_CLEAR_FLAG_BIT = 1;
  localparam int CTL_CLEAR_CONTROL_BIT = 2;
  // control register, read side
  localparam int STS_CONTROL_BIT = 0;
  localparam int STS_COMMAND_BIT = 1;
  localparam int STS_FLAG_BIT = 2;
  localparam int STS_ISO_RELAY_BIT = 3;
  localparam int STS_SETTLED_BIT = 4;

  // flag test register
  localparam int TEST_FLAG_SET_BIT = 0;
  localparam int TEST_FLAG_CLEAR_BIT = 1;

  // interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_RESPONSE_BIT = 0;
  localparam int IRQ_COMMAND_BIT = 1;
  localparam int IRQ_SETTLED_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 3'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned CMD_DELAY_US = 3000;
  localparam int unsigned RELAY_SETTLE_US = 1000;
  localparam int unsigned CMD_DELAY_CYCLES = CMD_DELAY_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned RELAY_SETTLE_CYCLES = RELAY_SETTLE_US * (CLK_FREQ_HZ / 1_000_000);

endpackage : relay_card_pkg

// >>> verilog/rise_detect.sv
// one-cycle pulse on the rising edge of a synchronous level
`timescale 1ns/1ps
module rise_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // level in, pulse out
  input wire logic level,
  output logic pulse
);

  logic level_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b0;
    end else if (ce) begin
      level_q <= level;
    end
  end

  // a level already high at reset release counts as an edge
  assign pulse = ce & level & ~level_q;

  a_pulse_on_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse |=> !pulse) else $error("rise pulse lasted more than one cycle");

endmodule : rise_detect

// >>> verilog/hold_delay.sv
// output follows input high only after it has stood for a fixed count
`timescale 1ns/1ps
module hold_delay #(
  parameter int unsigned CYCLES = 300000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // delayed level
  input wire logic level,
  output logic delayed
);

  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("hold_delay needs at least one cycle");
  end

  logic [CW-1:0] count;
  wire at_end = (count == CW'(CYCLES));

  // counter saturates, so the output holds as long as the input does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (ce) begin
      if (!level) begin
        count <= '0;
      end else if (!at_end) begin
        count <= count + 1'b1;
      end
    end
  end

  assign delayed = level & at_end;

  a_delay_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    !level |-> !delayed) else $error("delayed output high without input");
  a_delay_late: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(level) |-> !delayed) else $error("delayed output rose with input");

endmodule : hold_delay

// >>> verilog/relay_output_card.sv
// relay output card: relay word, command/flag logic, axi4-lite registers
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module relay_output_card
  import relay_card_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter bit READBACK = 1'b1,
  parameter int unsigned CMD_CYCLES = CMD_DELAY_CYCLES,
  parameter int unsigned SETTLE_CYCLES = RELAY_SETTLE_CYCLES
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // straps
  input wire logic low_group_preset_strap,
  input wire logic high_group_preset_strap,
  input wire logic command_relay_strap,
  // relays and device handshake
  output logic [RELAY_W-1:0] relay_drive,
  output logic isolated_command_relay,
  output logic ground_command,
  input wire logic response_isolated,
  input wire logic response_ground,
  // host interrupt chain
  input wire logic priority_in,
  output logic priority_out,
  output logic host_irq_request,
  output logic irq
);

  if (ADDR_W < MAP_ADDR_W || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data latched separately, either order

  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign awready = ce & ~aw_full & ~bvalid;
  assign wready = ce & ~w_full & ~bvalid;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire wr_fire = ce & aw_full & w_full & ~bvalid;
  wire wr_in_map = (aw_addr_q >> MAP_ADDR_W) == '0;
  wire [4:0] wr_off = aw_addr_q[4:0];
  wire wr_word = wr_fire & wr_in_map & (wr_off == OFF_OUTPUT_WORD);
  wire wr_ctl = wr_fire & wr_in_map & (wr_off == OFF_CONTROL);
  wire wr_test = wr_fire & wr_in_map & (wr_off == OFF_FLAG_TEST);
  wire wr_stat = wr_fire & wr_in_map & (wr_off == OFF_IRQ_STATUS);
  wire wr_mask = wr_fire & wr_in_map & (wr_off == OFF_IRQ_MASK);
  wire wr_hit = wr_word | wr_ctl | wr_test | wr_stat | wr_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (ce) begin
      aw_full <= aw_take | (aw_full & ~wr_fire);
      w_full <= w_take | (w_full & ~wr_fire);
      if (aw_take) aw_addr_q <= awaddr;
      if (w_take) w_data_q <= wdata;
      if (w_take) w_strb_q <= wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // relay word

  wire [RELAY_W-1:0] next_relay = {w_strb_q[1] ? w_data_q[15:8] : relay_drive[15:8],
                                   w_strb_q[0] ? w_data_q[7:0] : relay_drive[7:0]};
  wire load_word = wr_word & (w_strb_q[1:0] != 2'h0);

  // synchronous reset stands in for the power-on preset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_drive <= {{GROUP_W{high_group_preset_strap}}, {GROUP_W{low_group_preset_strap}}};
    end else if (ce && load_word) begin
      relay_drive <= next_relay;
    end
  end

  // settle timer restarts on every load; contacts need time to move
  logic settle_arm;
  logic relays_settled;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_arm <= 1'b0;
    end else if (ce) begin
      settle_arm <= ~load_word;
    end
  end

  hold_delay #(.CYCLES(SETTLE_CYCLES)) u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(settle_arm),
    .delayed(relays_settled)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command, control and flag

  wire ctl_lane = wr_ctl & w_strb_q[0];
  wire set_control_instr = ctl_lane & w_data_q[CTL_SET_CONTROL_BIT];
  wire clear_flag_instr = ctl_lane & w_data_q[CTL_CLEAR_FLAG_BIT];
  wire clear_control_instr = ctl_lane & w_data_q[CTL_CLEAR_CONTROL_BIT];
  logic resp_iso_pulse;
  logic resp_gnd_pulse;
  wire response = resp_iso_pulse | resp_gnd_pulse;

  rise_detect u_resp_iso (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(response_isolated),
    .pulse(resp_iso_pulse)
  );

  rise_detect u_resp_gnd (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(response_ground),
    .pulse(resp_gnd_pulse)
  );

  logic control_ff;
  logic command_ff;
  logic flag;
  logic cmd_delayed;
  logic cmd_delayed_q;
  logic settled_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_ff <= 1'b0;
      command_ff <= 1'b0;
      flag <= 1'b0;
    end else if (ce) begin
      if (set_control_instr) control_ff <= 1'b1;
      else if (clear_control_instr) control_ff <= 1'b0;
      if (set_control_instr) command_ff <= 1'b1;
      else if (response) command_ff <= 1'b0;
      // a response in the clearing cycle is kept
      if (response) flag <= 1'b1;
      else if (clear_flag_instr) flag <= 1'b0;
    end
  end

  hold_delay #(.CYCLES(CMD_CYCLES)) u_cmd_delay (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level(command_ff),
    .delayed(cmd_delayed)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isolated_command_relay <= 1'b0;
      ground_command <= 1'b0;
      cmd_delayed_q <= 1'b0;
      settled_q <= 1'b0;
    end else if (ce) begin
      isolated_command_relay <= command_relay_strap ? cmd_delayed : 1'b1;
      ground_command <= command_ff;
      cmd_delayed_q <= cmd_delayed;
      settled_q <= relays_settled;
    end
  end

  // priority chain: a requesting card blocks those below it
  wire requesting = flag & control_ff;
  assign host_irq_request = requesting & priority_in;
  assign priority_out = priority_in & ~requesting;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  wire [IRQ_W-1:0] irq_event = {relays_settled & ~settled_q, cmd_delayed & ~cmd_delayed_q, response};
  wire [IRQ_W-1:0] irq_w1c = (wr_stat & w_strb_q[0]) ? w_data_q[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= IRQ_STATUS_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else if (ce) begin
      irq_status <= (irq_status & ~irq_w1c) | irq_event;
      if (wr_mask && w_strb_q[0]) irq_mask <= w_data_q[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  assign arready = ce & ~rvalid;
  wire ar_take = arvalid & arready;
  wire rd_in_map = (araddr >> MAP_ADDR_W) == '0;
  wire [4:0] rd_off = araddr[4:0];
  wire rd_word = rd_in_map & (rd_off == OFF_OUTPUT_WORD);
  wire rd_ctl = rd_in_map & (rd_off == OFF_CONTROL);
  wire rd_test = rd_in_map & (rd_off == OFF_FLAG_TEST);
  wire rd_stat = rd_in_map & (rd_off == OFF_IRQ_STATUS);
  wire rd_mask = rd_in_map & (rd_off == OFF_IRQ_MASK);
  wire rd_hit = rd_word | rd_ctl | rd_test | rd_stat | rd_mask;
  wire [31:0] word_view = READBACK ? {16'h0, relay_drive} : 32'h0;
  wire [31:0] ctl_view = {27'h0, relays_settled, isolated_command_relay, flag, command_ff, control_ff};
  wire [31:0] test_view = {30'h0, ~flag, flag};
  wire [31:0] rd_data = rd_word ? word_view :
                        rd_ctl ? ctl_view :
                        rd_test ? test_view :
                        rd_stat ? {29'h0, irq_status} :
                        rd_mask ? {29'h0, irq_mask} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_preset_low_group: assert property ($rose(aresetn) |->
    relay_drive[7:0] == {GROUP_W{$past(low_group_preset_strap)}}) else $error("low group preset wrong");
  a_preset_high_group: assert property ($rose(aresetn) |->
    relay_drive[15:8] == {GROUP_W{$past(high_group_preset_strap)}}) else $error("high group preset wrong");
  a_word_load: assert property (ce && wr_word && w_strb_q[1:0] == 2'h3 |=>
    relay_drive == $past(w_data_q[15:0])) else $error("relay word not loaded");
  a_relay_hold: assert property (!(ce && load_word) |=> $stable(relay_drive))
    else $error("relays changed without a word load");
  a_set_control: assert property (ce && set_control_instr |=> control_ff && command_ff ##1 ground_command)
    else $error("set-control did not raise control and command");
  a_clear_flag: assert property (ce && clear_flag_instr && !response |=> !flag && !host_irq_request)
    else $error("clear-flag did not drop flag");
  a_response_flag: assert property (ce && response && !set_control_instr |=> flag && !command_ff ##1 !ground_command)
    else $error("response did not set flag and end command");
  a_host_request: assert property (host_irq_request == (flag && control_ff && priority_in))
    else $error("host request wrong");
  a_strap_removed: assert property (ce && !command_relay_strap |=> isolated_command_relay)
    else $error("isolated relay not held on");
  a_flag_test: assert property (ce && ar_take && rd_test |=> rdata[1:0] == {~$past(flag), $past(flag)})
    else $error("flag test read wrong");
  a_irq_level: assert property (irq == |(irq_status & irq_mask)) else $error("irq level wrong");

  c_word_load: cover property (ce && load_word);
  c_command_cycle: cover property (set_control_instr ##[1:1000] response);
  c_host_request: cover property ($rose(host_irq_request));
  c_masked_irq: cover property ($rose(irq));

endmodule : relay_output_card

// >>> verif/relay_device_model.sv
// behavioural external device that answers the card's command with a response
`timescale 1ns/1ps
module relay_device_model (
  // card side
  input wire logic aclk,
  input wire logic ground_command,
  input wire logic isolated_command_relay,
  // bench control
  input wire logic use_ground,
  input wire logic [3:0] reply_delay,
  // response lines, low while idle
  output logic response_isolated,
  output logic response_ground
);
  logic busy = 1'b0;
  logic [4:0] cnt = 5'h00;
  // one process owns each response level; the ports only mirror it
  logic iso_q = 1'b0;
  logic gnd_q = 1'b0;
  assign response_isolated = iso_q;
  assign response_ground = gnd_q;
  ////////////////////////////////////////
  // waits for both commands, so the delayed relay output is what releases it
  always @(posedge aclk) begin
    if (!busy) begin
      busy <= ground_command && isolated_command_relay;
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
      if (cnt == {1'b0, reply_delay}) begin
        gnd_q <= use_ground;
        iso_q <= !use_ground;
      end else if (cnt == {1'b0, reply_delay} + 5'h03) begin
        gnd_q <= 1'b0;
        iso_q <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule : relay_device_model

// >>> verif/tb.sv
// self-checking bench for the relay output card
`timescale 1ns/1ps
module tb
  import relay_card_pkg::*;
;
  localparam int CMD = 20;
  localparam int SET = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic low_group_preset_strap = 1'b1;
  logic high_group_preset_strap = 1'b0;
  logic command_relay_strap = 1'b1;
  logic priority_in = 1'b0;
  logic [15:0] relay_drive;
  logic isolated_command_relay, ground_command, response_isolated, response_ground;
  logic priority_out, host_irq_request, irq;
  logic use_ground = 1'b0;
  logic [3:0] reply_delay = 4'h4;
  int seed = 32922;
  int error_cnt = 0;
  int check_count = 0;
  logic [33:0] rq[$];
  logic [31:0] mq[$];
  logic [1:0] bq[$];
  logic [33:0] e_note;
  logic [31:0] m_note;

  always #5 aclk = ~aclk;

  relay_output_card #(.CMD_CYCLES(CMD), .SETTLE_CYCLES(SET)) uut (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .low_group_preset_strap, .high_group_preset_strap, .command_relay_strap, .relay_drive,
    .isolated_command_relay, .ground_command, .response_isolated, .response_ground,
    .priority_in, .priority_out, .host_irq_request, .irq
  );

  relay_device_model dev (
    .aclk, .ground_command, .isolated_command_relay, .use_ground, .reply_delay,
    .response_isolated, .response_ground
  );
  ////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic fail;
    error_cnt++;
    end_sim();
  endtask : fail

  task automatic wr(input logic [MAP_ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= {3'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) fail();
  endtask : wr

  // mask m hides status bits whose timing is not pinned down here
  task automatic rd(input logic [MAP_ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    int n;
    rq.push_back({r, e});
    mq.push_back(m);
    @(posedge aclk);
    araddr <= {3'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) fail();
  endtask : rd

  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  ////////////////////////////////////////
  always @(posedge aclk) begin
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready) begin
      m_note = mq.pop_front();
      e_note = rq.pop_front();
      chk({rresp, rdata & m_note}, {e_note[33:32], e_note[31:0] & m_note});
    end
  end

  initial begin
    logic [31:0] w;
    int n;
    rst();
    #1;
    chk(34'(relay_drive), 34'h00ff);
    for (int s = 0; s < 2; s++) begin
      w = $random(seed);
      use_ground <= s[0];
      priority_in <= s[0];
      reply_delay <= 4'($random(seed));
      wr(OFF_OUTPUT_WORD, w, RESP_OKAY);
      repeat (SET + 2) @(posedge aclk);
      #1;
      chk(34'(relay_drive), 34'(w[15:0]));
      rd(OFF_OUTPUT_WORD, {16'h0, w[15:0]}, 32'hffffffff, RESP_OKAY);
      wr(OFF_CONTROL, 32'h3, RESP_OKAY);
      @(posedge aclk);
      #1;
      chk(34'({ground_command, isolated_command_relay}), 34'h2);
      rd(OFF_CONTROL, 32'h13, 32'h1f, RESP_OKAY);
      for (n = 0; n < 40 && !isolated_command_relay; n++) @(posedge aclk);
      chk(34'(n >= CMD - 8 && n <= CMD + 2), 34'h1);
      for (n = 0; n < 40 && !(response_isolated || response_ground); n++) @(posedge aclk);
      repeat (3) @(posedge aclk);
      #1;
      chk(34'({ground_command, host_irq_request, priority_out}), 34'({1'b0, s[0], 1'b0}));
      rd(OFF_CONTROL, 32'h15, 32'h1f, RESP_OKAY);
      rd(OFF_FLAG_TEST, 32'h1, 32'h3, RESP_OKAY);
      // settle, delayed command and response have all risen by now
      rd(OFF_IRQ_STATUS, 32'h7, 32'h7, RESP_OKAY);
      chk(34'(irq), 34'h0);
      wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
      chk(34'(irq), 34'h1);
      wr(OFF_IRQ_STATUS, 32'h7, RESP_OKAY);
      chk(34'(irq), 34'h0);
      wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
      wr(OFF_CONTROL, 32'h2, RESP_OKAY);
      rd(OFF_FLAG_TEST, 32'h2, 32'h3, RESP_OKAY);
      #1;
      chk(34'({relay_drive, priority_out}), 34'({w[15:0], s[0]}));
    end
    wr(5'h14, 32'h0, RESP_SLVERR);
    rd(5'h14, 32'h0, 32'hffffffff, RESP_SLVERR);
    command_relay_strap <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    chk(34'(isolated_command_relay), 34'h1);
    command_relay_strap <= 1'b1;
    low_group_preset_strap <= 1'b0;
    high_group_preset_strap <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    chk(34'(relay_drive), 34'(w[15:0]));
    rst();
    #1;
    chk(34'(relay_drive), 34'hff00);
    end_sim();
  end
endmodule : tb
